// ---- rtl/csp_cfg.svh ----
`ifndef CSP_CFG_SVH
`define CSP_CFG_SVH

// Register byte offsets
`define CSP_OFF_CTRL 8'h00
`define CSP_OFF_STAT 8'h04
`define CSP_OFF_MASK 8'h08
`define CSP_OFF_DATA 8'h0c
`define CSP_OFF_TRIG 8'h10

// Field positions
`define CSP_CTRL_SRC_LSB 0
`define CSP_CTRL_SRC_MSB 1
`define CSP_CTRL_EDGE_BIT 2
`define CSP_STAT_DONE_BIT 0
`define CSP_STAT_RUN_BIT 1
`define CSP_STAT_ARM_BIT 2
`define CSP_MASK_DONE_BIT 0
`define CSP_TRIG_BIT 0

// Reset values
`define CSP_SRC_RST 2'h3
`define CSP_EDGE_RST 1'h0
`define CSP_MASK_RST 1'h0

// Clock source codes
`define CSP_SRC_CLK 2'h0
`define CSP_SRC_DIV2 2'h1
`define CSP_SRC_DIV4 2'h2
`define CSP_SRC_SLAVE 2'h3

// Master half period of the shift clock, in ref_clk cycles minus one
`define CSP_HALF_CLK 2'h0
`define CSP_HALF_DIV2 2'h1
`define CSP_HALF_DIV4 2'h3

`endif

// ---- rtl/csp_pkg.sv ----
package csp_pkg;

    // Transfer engine states
    typedef enum logic {
        CSP_IDLE,
        CSP_RUN
    } csp_state_e;

    // Software controlled settings of the port
    typedef struct packed {
        logic shift_edge_select;
        logic [1:0] clock_source_select;
    } csp_ctrl_s;

endpackage : csp_pkg

// ---- rtl/csp_top.sv ----
// What this block does
// - Edge select flips the driven clock pin; switch to slave before changing.
// - Reading the status while running aborts the transfer, back to idle.
// - Master shift clock is divided down from the system clock ref_clk.
// - Any read or write of the shift data arms the shift logic.
// - Source codes 0..3: CLK/2, CLK/4, CLK/8, external slave clock.
// - The done flag clears right after it is read.
// - Done flag sets on completion even when the mask is zero.
//
// The address map and the Wishbone interface to the registers were chosen for this implementation.
`timescale 1ns/1ps
`include "csp_cfg.svh"

module csp_top
    import csp_pkg::*;
#(
    parameter int DW = 8
) (
    input wire logic ref_clk,
    input wire logic rst_b,
    input wire logic ce,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    output logic irq,
    input wire logic sclk_i,
    output logic sclk_o,
    output logic sclk_oe_b,
    input wire logic sdi,
    output logic sdo
);

    localparam int CW = $clog2(DW + 1);

    // Pin synchronisers; the third clock flop only serves edge detection
    logic sclk_s1_q;
    logic sclk_s2_q;
    logic sclk_s3_q;
    logic sdi_s1_q;
    logic sdi_s2_q;

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            sclk_s1_q <= 1'h1;
            sclk_s2_q <= 1'h1;
            sclk_s3_q <= 1'h1;
            sdi_s1_q <= 1'h0;
            sdi_s2_q <= 1'h0;
        end else if (ce) begin
            sclk_s1_q <= sclk_i;
            sclk_s2_q <= sclk_s1_q;
            sclk_s3_q <= sclk_s2_q;
            sdi_s1_q <= sdi;
            sdi_s2_q <= sdi_s1_q;
        end
    end

    // State registers
    csp_state_e st_q, st_d;
    csp_ctrl_s ctrl_q, ctrl_d;
    logic mask_q, mask_d;
    logic done_q, done_d;
    logic armed_q, armed_d;
    logic [DW-1:0] shreg_q, shreg_d;
    logic [CW-1:0] cnt_q, cnt_d;
    logic [1:0] div_q, div_d;
    logic lvl_q, lvl_d;
    logic sdo_q, sdo_d;
    logic ack_q, ack_d;
    logic [31:0] rdat_q, rdat_d;

    // Bus decode
    logic take;
    logic wr;
    logic rd;
    logic hit_ctrl;
    logic hit_stat;
    logic hit_mask;
    logic hit_data;
    logic hit_trig;

    assign take = wb_cyc_i & wb_stb_i & ~ack_q;
    assign wr = take & wb_we_i & wb_sel_i[0];
    assign rd = take & ~wb_we_i;
    assign hit_ctrl = wb_adr_i == `CSP_OFF_CTRL;
    assign hit_stat = wb_adr_i == `CSP_OFF_STAT;
    assign hit_mask = wb_adr_i == `CSP_OFF_MASK;
    assign hit_data = wb_adr_i == `CSP_OFF_DATA;
    assign hit_trig = wb_adr_i == `CSP_OFF_TRIG;

    // Shift clock events, expressed on the edge-neutral level
    logic slave;
    logic [1:0] half_m1;
    logic tick;
    logic slv_now;
    logic slv_prev;
    logic samp_evt;
    logic out_evt;
    logic trig;
    logic abort;
    logic done_set;
    logic done_clr;

    assign slave = ctrl_q.clock_source_select == `CSP_SRC_SLAVE;
    assign slv_now = sclk_s2_q ^ ctrl_q.shift_edge_select;
    assign slv_prev = sclk_s3_q ^ ctrl_q.shift_edge_select;
    assign tick = div_q == half_m1;
    assign trig = wr & hit_trig & wb_dat_i[`CSP_TRIG_BIT];
    assign abort = rd & hit_stat & (st_q == CSP_RUN);
    assign done_clr = (rd & hit_stat)
        | (wr & hit_stat & wb_dat_i[`CSP_STAT_DONE_BIT]);

    // Master divider: the pin clock is cut from ref_clk for every source except the slave code
    always_comb begin
        case (ctrl_q.clock_source_select)
            `CSP_SRC_CLK: half_m1 = `CSP_HALF_CLK;
            `CSP_SRC_DIV2: half_m1 = `CSP_HALF_DIV2;
            `CSP_SRC_DIV4: half_m1 = `CSP_HALF_DIV4;
            default: half_m1 = `CSP_HALF_CLK;
        endcase
    end

    // Sample on the rising neutral edge, drive out on the falling one
    always_comb begin
        if (slave) begin
            samp_evt = slv_now & ~slv_prev;
            out_evt = ~slv_now & slv_prev;
        end else begin
            samp_evt = tick & ~lvl_q;
            out_evt = tick & lvl_q;
        end
    end

    // Next state of the engine and the register file
    always_comb begin
        st_d = st_q;
        ctrl_d = ctrl_q;
        mask_d = mask_q;
        armed_d = armed_q;
        shreg_d = shreg_q;
        cnt_d = cnt_q;
        div_d = div_q;
        lvl_d = lvl_q;
        sdo_d = sdo_q;
        done_set = 1'h0;
        case (st_q)
            CSP_IDLE: begin
                lvl_d = 1'h1;
                div_d = 2'h0;
                if (trig && armed_q) begin
                    st_d = CSP_RUN;
                    cnt_d = '0;
                    armed_d = 1'h0;
                    sdo_d = shreg_q[DW-1];
                end
            end
            CSP_RUN: begin
                if (!slave) begin
                    div_d = tick ? 2'h0 : div_q + 2'h1;
                    lvl_d = tick ? ~lvl_q : lvl_q;
                end
                if (samp_evt) begin
                    shreg_d = {shreg_q[DW-2:0], sdi_s2_q};
                    cnt_d = cnt_q + CW'(1);
                    if (cnt_q == CW'(DW - 1)) begin
                        st_d = CSP_IDLE;
                        done_set = 1'h1;
                    end
                end
                if (out_evt) begin
                    sdo_d = shreg_q[DW-1];
                end
            end
            default: st_d = CSP_IDLE;
        endcase
        if (abort) begin
            st_d = CSP_IDLE;
            armed_d = 1'h0;
            lvl_d = 1'h1;
            div_d = 2'h0;
        end
        if (take && hit_data) begin
            armed_d = 1'h1;
        end
        if (wr && hit_data) begin
            shreg_d = wb_dat_i[DW-1:0];
        end
        if (wr && hit_ctrl) begin
            // Flipping the edge here inverts a driven pin at once
            ctrl_d.shift_edge_select = wb_dat_i[`CSP_CTRL_EDGE_BIT];
            ctrl_d.clock_source_select =
                wb_dat_i[`CSP_CTRL_SRC_MSB:`CSP_CTRL_SRC_LSB];
        end
        if (wr && hit_mask) begin
            mask_d = wb_dat_i[`CSP_MASK_DONE_BIT];
        end
        // Set wins over a clear in the same cycle; the mask plays no part
        done_d = (done_q & ~done_clr) | done_set;
    end

    // Read data and acknowledge, one cycle after the request is taken
    always_comb begin
        ack_d = take;
        rdat_d = 32'h0;
        if (rd) begin
            if (hit_ctrl) begin
                rdat_d[`CSP_CTRL_SRC_MSB:`CSP_CTRL_SRC_LSB] =
                    ctrl_q.clock_source_select;
                rdat_d[`CSP_CTRL_EDGE_BIT] = ctrl_q.shift_edge_select;
            end
            if (hit_stat) begin
                rdat_d[`CSP_STAT_DONE_BIT] = done_q;
                rdat_d[`CSP_STAT_RUN_BIT] = st_q == CSP_RUN;
                rdat_d[`CSP_STAT_ARM_BIT] = armed_q;
            end
            if (hit_mask) begin
                rdat_d[`CSP_MASK_DONE_BIT] = mask_q;
            end
            if (hit_data) begin
                rdat_d[DW-1:0] = shreg_q;
            end
        end
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            st_q <= CSP_IDLE;
            ctrl_q <= {`CSP_EDGE_RST, `CSP_SRC_RST};
            mask_q <= `CSP_MASK_RST;
            done_q <= 1'h0;
            armed_q <= 1'h0;
            shreg_q <= '0;
            cnt_q <= '0;
            div_q <= 2'h0;
            lvl_q <= 1'h1;
            sdo_q <= 1'h0;
            ack_q <= 1'h0;
            rdat_q <= 32'h0;
        end else if (ce) begin
            st_q <= st_d;
            ctrl_q <= ctrl_d;
            mask_q <= mask_d;
            done_q <= done_d;
            armed_q <= armed_d;
            shreg_q <= shreg_d;
            cnt_q <= cnt_d;
            div_q <= div_d;
            lvl_q <= lvl_d;
            sdo_q <= sdo_d;
            ack_q <= ack_d;
            rdat_q <= rdat_d;
        end
    end

    // Outputs; pin drive follows the source, even when idle
    assign wb_ack_o = ack_q;
    assign wb_dat_o = rdat_q;
    assign sclk_o = lvl_q ^ ctrl_q.shift_edge_select;
    assign sclk_oe_b = slave;
    assign sdo = sdo_q;
    assign irq = done_q & mask_q;

    // Checks
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!rst_b || !ce);

    property p_abort;
        rd && hit_stat && st_q == CSP_RUN |=> st_q == CSP_IDLE && !armed_q;
    endproperty
    a_abort: assert property (p_abort) else $error("read did not abort");

    property p_clr;
        rd && hit_stat && !done_set |=> !done_q;
    endproperty
    a_clr: assert property (p_clr) else $error("done flag not cleared");

    property p_done;
        done_set |=> done_q && st_q == CSP_IDLE;
    endproperty
    a_done: assert property (p_done) else $error("done flag not set");

    // Follows the flag through its own register, not the output gate alone
    property p_irq;
        done_set && mask_q && !(wr && hit_mask) |=> irq;
    endproperty
    a_irq: assert property (p_irq) else $error("interrupt missing");

    property p_arm;
        take && hit_data |=> armed_q;
    endproperty
    a_arm: assert property (p_arm) else $error("data access did not arm");

    property p_noarm;
        trig && !armed_q && st_q == CSP_IDLE |=> st_q == CSP_IDLE;
    endproperty
    a_noarm: assert property (p_noarm) else $error("unarmed trigger ran");

    property p_drive;
        !slave |-> !sclk_oe_b ##0 (st_q == CSP_IDLE || div_q <= half_m1);
    endproperty
    a_drive: assert property (p_drive) else $error("master not driving");

    property p_div4;
        st_q == CSP_RUN && !abort && ctrl_q.clock_source_select ==
        `CSP_SRC_DIV4 && $changed(lvl_q) |=> $stable(lvl_q)[*3];
    endproperty
    a_div4: assert property (p_div4) else $error("quarter rate wrong");

    property p_ack;
        take |=> wb_ack_o ##1 !wb_ack_o;
    endproperty
    a_ack: assert property (p_ack) else $error("ack timing wrong");

endmodule : csp_top

// ---- tb/csp_peer.sv ----
`timescale 1ns/1ps
module csp_peer (
    input wire logic sclk,
    input wire logic sdo,
    output logic sdi,
    output logic sclk_drv,
    output logic [7:0] rx
);
    logic [7:0] sh_q;
    logic seen_q;

    // MSB leaves first; held until a rise has sampled it
    assign sdi = sh_q[7];

    initial begin
        sclk_drv = 1'b1;
        sh_q = 8'h00;
        seen_q = 1'b0;
    end

    task automatic load(input logic [7:0] v);
        sh_q = v;
        rx = 8'h00;
        seen_q = 1'b0;
    endtask : load

    // Clock runs only inside a frame, idle high, 125 ns period
    task automatic frame;
        repeat (8) begin
            sclk_drv = 1'b0;
            #62.5;
            sclk_drv = 1'b1;
            #62.5;
        end
    endtask : frame

    // Sample on the rise, move on at the fall after it
    always @(posedge sclk) begin
        rx <= {rx[6:0], sdo};
        seen_q <= 1'b1;
    end
    always @(negedge sclk) begin
        if (seen_q) sh_q <= {sh_q[6:0], ~sh_q[0]};
    end
endmodule : csp_peer

// ---- tb/clocked_serial_port_control_test.sv ----
`timescale 1ns/1ps
`include "csp_cfg.svh"
module clocked_serial_port_control_test;
    logic ref_clk = 1'b0;
    logic rst_b = 1'b0;
    logic ce = 1'b1;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic we = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [31:0] wdat = 32'h0;
    logic [31:0] rdat, rd;
    logic ack, irq, sclk_o, oe_b, sdi, sdo, pclk, sclk, prev;
    logic [7:0] prx;
    int errors = 0;
    int cmp_count = 0;
    int cnt = 0;
    int per = 0;

    // Fixed system clock, never switched mid transfer
    always #2.5 ref_clk = ~ref_clk;
    // Pin level: whichever end is enabled drives it
    assign sclk = oe_b ? pclk : sclk_o;

    csp_top u_csp_top (.ref_clk(ref_clk), .rst_b(rst_b), .ce(ce),
        .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
        .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(rdat),
        .wb_ack_o(ack), .irq(irq), .sclk_i(sclk), .sclk_o(sclk_o),
        .sclk_oe_b(oe_b), .sdi(sdi), .sdo(sdo));
    csp_peer u_csp_peer (.sclk(sclk), .sdo(sdo), .sdi(sdi),
        .sclk_drv(pclk), .rx(prx));

    // Spacing of pin falls, to check the master divider
    always @(posedge ref_clk) begin
        prev <= sclk_o;
        cnt <= (prev === 1'b1 && !sclk_o) ? 1 : cnt + 1;
        if (prev === 1'b1 && !sclk_o) per <= cnt;
    end

    task automatic chk(input string nm, input logic [31:0] s, e);
        cmp_count++;
        if (s !== e) begin
            errors++;
            $display("Error %s exp %h seen %h", nm, e, s);
        end
    endtask : chk

    // One classic cycle; hold until ack is sampled high, the watchdog
    // alone ends a wait that never gets its answer
    task automatic acc(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        @(posedge ref_clk);
        while (ack !== 1'b1) begin
            @(posedge ref_clk);
        end
        rd = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge ref_clk);
    endtask : acc

    task automatic results;
        if (errors == 0 && cmp_count > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : results

    // Watchdog: the whole run needs a few microseconds
    initial begin
        #30000;
        errors++;
        results;
    end

    // Main sequence
    initial begin
        int n;
        repeat (8) @(posedge ref_clk);
        rst_b <= 1'b1;
        @(posedge ref_clk);
        acc(0, `CSP_OFF_CTRL, 0);
        chk("ctrl", rd, 32'h3);
        chk("oe_b", oe_b, 1);
        acc(0, 8'h20, 0);
        chk("unmap", rd, 0);
        acc(1, `CSP_OFF_MASK, 1);
        for (int s = 0; s < 3; s++) begin
            acc(1, `CSP_OFF_CTRL, s);
            u_csp_peer.load(8'h3c);
            acc(1, `CSP_OFF_DATA, 32'ha5);
            acc(1, `CSP_OFF_TRIG, 1);
            n = 0;
            while (irq !== 1'b1 && n < 500) begin
                @(posedge ref_clk);
                n++;
            end
            chk("period", per, 2 << s);
            chk("irq", irq, 1);
            chk("sent", prx, 8'ha5);
            acc(0, `CSP_OFF_DATA, 0);
            if (s == 2) chk("recv", rd, 8'h3c);
            acc(0, `CSP_OFF_STAT, 0);
            chk("stat", rd[2:0], 3'h5);
            acc(0, `CSP_OFF_STAT, 0);
            chk("clr", rd[0], 0);
            chk("irq off", irq, 0);
        end
        acc(1, `CSP_OFF_MASK, 0);
        acc(1, `CSP_OFF_CTRL, 3);
        u_csp_peer.load(8'h69);
        acc(1, `CSP_OFF_DATA, 32'h96);
        acc(1, `CSP_OFF_TRIG, 1);
        #1.3 u_csp_peer.frame();
        repeat (10) @(posedge ref_clk);
        chk("irq mask", irq, 0);
        chk("sent", prx, 8'h96);
        acc(0, `CSP_OFF_DATA, 0);
        chk("recv", rd, 8'h69);
        acc(0, `CSP_OFF_STAT, 0);
        chk("stat", rd[1:0], 2'h1);
        acc(1, `CSP_OFF_CTRL, 2);
        acc(1, `CSP_OFF_DATA, 32'h5a);
        acc(1, `CSP_OFF_TRIG, 1);
        repeat (6) @(posedge ref_clk);
        // Freeze longer than a whole transfer; it must still be running
        ce <= 1'b0;
        fork
            acc(0, `CSP_OFF_STAT, 0);
            begin
                repeat (80) @(posedge ref_clk);
                chk("frozen ack", ack, 0);
                ce <= 1'b1;
            end
        join
        chk("run", rd[1], 1);
        acc(0, `CSP_OFF_STAT, 0);
        chk("abort", rd[2:0], 0);
        chk("idle", sclk_o, 1);
        acc(1, `CSP_OFF_TRIG, 1);
        acc(0, `CSP_OFF_STAT, 0);
        chk("no run", rd[1], 0);
        // Edge select changes only while the pin belongs to the peer
        acc(1, `CSP_OFF_CTRL, 32'h7);
        acc(1, `CSP_OFF_CTRL, 32'h6);
        acc(0, `CSP_OFF_CTRL, 0);
        chk("edge", rd, 32'h6);
        chk("edge idle", sclk_o, 0);
        chk("oe_b drv", oe_b, 0);
        results;
    end
endmodule : clocked_serial_port_control_test
